// >>> core/apie_pkg.sv
// Shared constants for the axis position init and error status block.
// Assumes a single board clock; all users refer to names as apie_pkg::name.
package apie_pkg;

  // Board geometry.
  localparam int NUM_AXES = 4;
  localparam int NUM_CH   = 4;
  localparam int POS_W    = 32;
  localparam int DELTA_W  = 8;
  localparam int REF_W    = 8;
  localparam int ERR_W    = 32;

  // Field positions in the board error status register.
  localparam int AC_LSB   = 0;
  localparam int DC_LSB   = 4;
  localparam int SQ_LSB   = 8;
  localparam int LOL_LSB  = 12;
  localparam int BPL_BIT  = 16;
  localparam int REF_BIT  = 17;
  localparam int CMP_LSB  = 18;
  localparam int OVF_LSB  = 22;
  localparam int DNV_LSB  = 26;

  // Reset values.
  localparam logic [ERR_W-1:0] ERR_RESET = 32'h0000_0000;
  localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;

  // Clock source select codes; code 2 is unused and behaves as code 0.
  localparam logic [1:0] CLK_MODE_INT   = 2'h0;
  localparam logic [1:0] CLK_MODE_EXT   = 2'h1;
  localparam logic [1:0] CLK_MODE_DRIVE = 2'h3;

endpackage : apie_pkg

// >>> core/apie_clk_select.sv
// Board clock source selection from the two select bits.
// Assumes select bits and slave strap are synchronous to clk.
`timescale 1ns/10ps
module apie_clk_select
(
  input  wire logic clk,
  input  wire logic rstN,
  input  wire logic ce,
  input  wire logic selHi,
  input  wire logic selLo,
  input  wire logic isSlave,
  output logic      useBpClk,
  output logic      bpClkOe
);

  logic useBp_ff;
  logic drive_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  // A slave takes its timing from the reference cable, so it never listens to the backplane.
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      useBp_ff <= 1'b0;
      drive_ff <= 1'b0;
    end
    else if (ce)
    begin
      useBp_ff <= ({selHi, selLo} == apie_pkg::CLK_MODE_EXT) && !isSlave;
      drive_ff <= ({selHi, selLo} == apie_pkg::CLK_MODE_DRIVE);
    end
  end

  assign useBpClk = useBp_ff;
  assign bpClkOe  = drive_ff;

  property p_slave_blocked;
    isSlave |=> !useBpClk;
  endproperty
  a_slave_blocked: assert property (p_slave_blocked)
    else $error("Slave board accepted backplane clock.");

  property p_mode_drive;
    ce && {selHi, selLo} == apie_pkg::CLK_MODE_DRIVE |=> bpClkOe && !useBpClk;
  endproperty
  a_mode_drive: assert property (p_mode_drive)
    else $error("Clock mode three does not drive backplane clock.");

  property p_mode_int;
    ce && {selHi, selLo} == apie_pkg::CLK_MODE_INT |=> !bpClkOe && !useBpClk;
  endproperty
  a_mode_int: assert property (p_mode_int)
    else $error("Default clock mode drives or uses backplane clock.");

endmodule : apie_clk_select

// >>> core/apie_axis_counter.sv
// One axis position counter with load and overflow detection.
// Assumes the load request and value are settled before the clock edge.
`timescale 1ns/10ps
module apie_axis_counter
#(
  parameter int POS_W   = apie_pkg::POS_W,
  parameter int DELTA_W = apie_pkg::DELTA_W
)
(
  input  wire logic                      clk,
  input  wire logic                      rstN,
  input  wire logic                      ce,
  input  wire logic signed [DELTA_W-1:0] delta,
  input  wire logic                      loadEn,
  input  wire logic        [POS_W-1:0]   loadVal,
  output logic             [POS_W-1:0]   pos,
  output logic                           ovf
);

  logic        [POS_W-1:0] pos_ff;
  logic                    ovf_ff;
  logic signed [POS_W:0]   sum;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  // One guard bit catches both overflow and underflow of the signed count.
  always_comb
  begin
    sum = signed'({pos_ff[POS_W-1], pos_ff}) + (POS_W+1)'(delta);
  end

  // A load overrides counting; the preset shares the counter's LSB weight.
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pos_ff <= apie_pkg::POS_RESET;
      ovf_ff <= 1'b0;
    end
    else if (ce)
    begin
      pos_ff <= loadEn ? loadVal : sum[POS_W-1:0];
      ovf_ff <= !loadEn && (sum[POS_W] != sum[POS_W-1]);
    end
  end

  assign pos = pos_ff;
  assign ovf = ovf_ff;

  property p_load;
    ce && loadEn |=> pos == $past(loadVal);
  endproperty
  a_load: assert property (p_load)
    else $error("Counter did not take load value.");

endmodule : apie_axis_counter

// >>> core/apie_top.sv
// Axis position initialisation, clock source select and error status latching.
// Assumes all inputs are synchronous to clk; rst_n may assert asynchronously.
`timescale 1ns/10ps
module apie_top
#(
  parameter int NA = apie_pkg::NUM_AXES,
  parameter int NC = apie_pkg::NUM_CH,
  parameter int PW = apie_pkg::POS_W,
  parameter int DW = apie_pkg::DELTA_W,
  parameter int RW = apie_pkg::REF_W
)
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire logic                 clockSourceSelectHi,
  input  wire logic                 clockSourceSelectLo,
  input  wire logic                 isSlave,
  input  wire logic        [NA-1:0] presetSel,
  input  wire logic        [PW-1:0] presetValue [NA],
  input  wire logic        [NA-1:0] rowResetEn,
  input  wire logic        [NA-1:0] axisResetIn,
  input  wire logic                 positionResetN,
  input  wire logic                 cmdWrite,
  input  wire logic        [NA-1:0] cmdResetPos,
  input  wire logic signed [DW-1:0] posDelta [NA],
  input  wire logic        [NC-1:0] chanUse [NA],
  input  wire logic        [NC-1:0] acHigh,
  input  wire logic        [NC-1:0] dcHigh,
  input  wire logic        [NC-1:0] belowSquelch,
  input  wire logic        [NC-1:0] phaseTrackFailure,
  input  wire logic        [NC-1:0] overTemp,
  input  wire logic                 bpPllUnlock,
  input  wire logic        [RW-1:0] refErrBits,
  input  wire logic        [NA-1:0] cmpHit,
  input  wire logic                 errClrWrite,
  input  wire logic        [31:0]   errClrData,
  input  wire logic        [31:0]   irqMask,
  input  wire logic        [31:0]   axisErrMask [NA],
  output logic             [PW-1:0] axisPosition [NA],
  output logic             [31:0]   boardErrorStatus,
  output logic                      irqOut,
  output logic                      errLineOut,
  output logic                      chainDataInvalid,
  output logic                      useBackplaneClk,
  output logic                      bpClkOe
);

  logic              rstMeta_ff;
  logic              rstSync_ff;
  logic [NA-1:0]     cmdStrobe_ff;
  logic [NA-1:0]     loadEn;
  logic [PW-1:0]     loadVal [NA];
  logic [NA-1:0]     axisOvf;
  logic [31:0]       status_ff;
  logic [31:0]       evt;
  logic [31:0]       clrMask;
  logic              irq_ff;
  logic              errLine_ff;
  logic              chainInv_ff;
  logic              errHit;
  logic [NC-1:0]     chanFault;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_ff);

  // True when any channel in use by an axis shows a fault.
  function automatic logic usedFault(input logic [NC-1:0] used, input logic [NC-1:0] flt);
    usedFault = |(used & flt);
  endfunction : usedFault

  // Reset is released through two flops so every flop leaves reset on the same edge.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end
    else
    begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  apie_clk_select u_clk_select
  (
    .clk      (clk),
    .rstN     (rstSync_ff),
    .ce       (ce),
    .selHi    (clockSourceSelectHi),
    .selLo    (clockSourceSelectLo),
    .isSlave  (isSlave),
    .useBpClk (useBackplaneClk),
    .bpClkOe  (bpClkOe)
  );

  // The command bits are registered only while cmdWrite is high, so a held write reloads every cycle.
  always_ff @(posedge clk or negedge rstSync_ff)
  begin
    if (!rstSync_ff)
    begin
      cmdStrobe_ff <= '0;
    end
    else if (ce)
    begin
      cmdStrobe_ff <= cmdWrite ? cmdResetPos : '0;
    end
  end

  // Load sources per axis; the backplane line is gated only by rowResetEn, with no address qualification.
  genvar a;
  generate
    for (a = 0; a < NA; a++)
    begin : g_axis
      always_comb
      begin
        loadEn[a]  = !positionResetN || cmdStrobe_ff[a]
                     || (rowResetEn[a] && axisResetIn[a]);
        loadVal[a] = ((!positionResetN || cmdStrobe_ff[a]) && presetSel[a])
                     ? presetValue[a] : apie_pkg::POS_RESET;
      end

      apie_axis_counter #(.POS_W(PW), .DELTA_W(DW)) u_counter
      (
        .clk     (clk),
        .rstN    (rstSync_ff),
        .ce      (ce),
        .delta   (posDelta[a]),
        .loadEn  (loadEn[a]),
        .loadVal (loadVal[a]),
        .pos     (axisPosition[a]),
        .ovf     (axisOvf[a])
      );
    end
  endgenerate

  // Live error events and the write-one clear mask, including clears implied by data not valid.
  always_comb
  begin
    evt       = '0;
    chanFault = acHigh | dcHigh | phaseTrackFailure | overTemp;
    clrMask   = errClrWrite ? errClrData : '0;
    for (int c = 0; c < NC; c++)
    begin
      evt[apie_pkg::AC_LSB + c]  = acHigh[c];
      evt[apie_pkg::DC_LSB + c]  = dcHigh[c];
      evt[apie_pkg::SQ_LSB + c]  = belowSquelch[c];
      evt[apie_pkg::LOL_LSB + c] = phaseTrackFailure[c] | overTemp[c];
    end
    evt[apie_pkg::BPL_BIT] = bpPllUnlock && useBackplaneClk;
    evt[apie_pkg::REF_BIT] = isSlave && (|refErrBits);
    for (int x = 0; x < NA; x++)
    begin
      evt[apie_pkg::CMP_LSB + x] = cmpHit[x];
      evt[apie_pkg::OVF_LSB + x] = axisOvf[x];
      evt[apie_pkg::DNV_LSB + x] = usedFault(chanUse[x], chanFault)
                                   || evt[apie_pkg::BPL_BIT]
                                   || evt[apie_pkg::REF_BIT];
      if (errClrWrite && errClrData[apie_pkg::DNV_LSB + x])
      begin
        for (int c = 0; c < NC; c++)
        begin
          if (chanUse[x][c])
          begin
            clrMask[apie_pkg::AC_LSB + c]  = 1'b1;
            clrMask[apie_pkg::DC_LSB + c]  = 1'b1;
            clrMask[apie_pkg::LOL_LSB + c] = 1'b1;
          end
        end
        clrMask[apie_pkg::BPL_BIT] = 1'b1;
        clrMask[apie_pkg::REF_BIT] = 1'b1;
      end
    end
  end

  // A live cause wins over a same-cycle clear, so a bit only drops once its cause is gone.
  always_ff @(posedge clk or negedge rstSync_ff)
  begin
    if (!rstSync_ff)
    begin
      status_ff <= apie_pkg::ERR_RESET;
    end
    else if (ce)
    begin
      status_ff <= (status_ff & ~clrMask) | evt;
    end
  end

  // Any axis mask that hits a latched error activates the backplane error line.
  always_comb
  begin
    errHit = 1'b0;
    for (int x = 0; x < NA; x++)
    begin
      errHit = errHit || (|(status_ff & axisErrMask[x]));
    end
  end

  // Outputs are registered one cycle behind the status they summarise.
  always_ff @(posedge clk or negedge rstSync_ff)
  begin
    if (!rstSync_ff)
    begin
      irq_ff      <= 1'b0;
      errLine_ff  <= 1'b0;
      chainInv_ff <= 1'b0;
    end
    else if (ce)
    begin
      irq_ff      <= |(status_ff & irqMask);
      errLine_ff  <= errHit;
      chainInv_ff <= status_ff[apie_pkg::BPL_BIT];
    end
  end

  assign boardErrorStatus = status_ff;
  assign irqOut           = irq_ff;
  assign errLineOut       = errLine_ff;
  assign chainDataInvalid = chainInv_ff;

  property p_cmd_zero;
    ce && cmdStrobe_ff[0] && !presetSel[0] |=> axisPosition[0] == apie_pkg::POS_RESET;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero)
    else $error("Command reset did not zero axis one.");

  property p_cmd_once;
    ce && cmdWrite && cmdResetPos[1] ##1 ce && !cmdWrite |=> !cmdStrobe_ff[1];
  endproperty
  a_cmd_once: assert property (p_cmd_once)
    else $error("Reset-position strobe lasted more than one cycle.");

  property p_hw_zero;
    ce && !positionResetN && !presetSel[0] |=> axisPosition[0] == apie_pkg::POS_RESET;
  endproperty
  a_hw_zero: assert property (p_hw_zero)
    else $error("Hardware reset did not zero axis one.");

  property p_hw_preset;
    ce && !positionResetN && presetSel[1] |=> axisPosition[1] == $past(presetValue[1]);
  endproperty
  a_hw_preset: assert property (p_hw_preset)
    else $error("Hardware reset did not preset axis two.");

  property p_row_reset;
    ce && rowResetEn[2] && axisResetIn[2] && positionResetN && !cmdStrobe_ff[2]
      |=> axisPosition[2] == apie_pkg::POS_RESET;
  endproperty
  a_row_reset: assert property (p_row_reset)
    else $error("Row reset did not zero axis three.");

  property p_hold;
    ce && status_ff[apie_pkg::SQ_LSB + 2] && !clrMask[apie_pkg::SQ_LSB + 2]
      |=> status_ff[apie_pkg::SQ_LSB + 2];
  endproperty
  a_hold: assert property (p_hold)
    else $error("Latched error bit dropped without a clear.");

  property p_ac_dnv;
    ce && acHigh[0] && chanUse[0][0]
      |=> status_ff[apie_pkg::AC_LSB] && status_ff[apie_pkg::DNV_LSB];
  endproperty
  a_ac_dnv: assert property (p_ac_dnv)
    else $error("AC too high did not latch with data not valid.");

  property p_bp_lock;
    ce && useBackplaneClk && bpPllUnlock
      |=> status_ff[apie_pkg::BPL_BIT] && (&status_ff[apie_pkg::DNV_LSB +: 4]);
  endproperty
  a_bp_lock: assert property (p_bp_lock)
    else $error("Backplane lock error did not invalidate all axes.");

  property p_irq;
    ce && acHigh[0] && irqMask[apie_pkg::AC_LSB] ##1 ce |=> irqOut;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Unmasked error did not raise the interrupt.");

endmodule : apie_top

// >>> tb/apie_host_model.sv
// Model of the host processor and backplane that drive the command, clear and reset lines.
// Assumes it shares the board clock; its tasks are called from the testbench top.
`timescale 1ns/10ps
module apie_host_model
(
  input  wire logic        clk,
  output logic             cmdWrite,
  output logic      [3:0]  cmdResetPos,
  output logic             errClrWrite,
  output logic      [31:0] errClrData,
  output logic             positionResetN,
  output logic      [3:0]  axisResetIn
);
  // Idle bus at time zero; the position reset line has a pull-up, so idle is high.
  initial
  begin
    cmdWrite       = 1'b0;
    cmdResetPos    = 4'h0;
    errClrWrite    = 1'b0;
    errClrData     = 32'h0000_0000;
    positionResetN = 1'b1;
    axisResetIn    = 4'h0;
  end

  // One-cycle command write; released data shows the inverse so stale bits are never reused.
  task automatic sendCmd(input logic [3:0] m);
    @(posedge clk);
    cmdWrite    <= 1'b1;
    cmdResetPos <= m;
    @(posedge clk);
    cmdWrite    <= 1'b0;
    cmdResetPos <= ~m;
  endtask : sendCmd

  // Error clear write; a single board stands here, so it is cleared before any chained one.
  task automatic sendClr(input logic [31:0] d);
    @(posedge clk);
    errClrWrite <= 1'b1;
    errClrData  <= d;
    @(posedge clk);
    errClrWrite <= 1'b0;
    errClrData  <= ~d;
  endtask : sendClr

  // Backplane reset lines are levels and stay as set until the next call.
  task automatic setLines(input logic rstN, input logic [3:0] ax);
    @(posedge clk);
    positionResetN <= rstN;
    axisResetIn    <= ax;
  endtask : setLines
endmodule : apie_host_model

// >>> tb/apie_top_tb_top.sv
// Self-checking testbench for the axis position init and error status block.
// Assumes the host model drives command, clear and backplane reset lines.
`timescale 1ns/10ps
module apie_top_tb_top;
  logic              clk;
  logic              rst_n;
  logic              selHi;
  logic              selLo;
  logic              isSlave;
  logic              bpPllUnlock;
  logic              cmdWrite;
  logic              errClrWrite;
  logic              positionResetN;
  logic              irqOut;
  logic              errLineOut;
  logic              chainDataInvalid;
  logic              useBackplaneClk;
  logic              bpClkOe;
  logic       [3:0]  presetSel, rowResetEn, axisResetIn, cmdResetPos, cmpHit;
  logic       [3:0]  acHigh, dcHigh, belowSquelch, phaseTrackFailure, overTemp;
  logic       [7:0]  refErrBits;
  logic       [31:0] errClrData, irqMask, boardErrorStatus, p2;
  logic       [31:0] presetValue [4];
  logic       [31:0] axisErrMask [4];
  logic       [31:0] axisPosition [4];
  logic       [3:0]  chanUse [4];
  logic signed [7:0] posDelta [4];
  int                errors;
  int                nTests;
  // Expected status per fault case: channel, squelch, lock, backplane, reference, event bits.
  logic       [31:0] expTab [10] = '{32'h0400_0001, 32'h0800_0020, 32'h0000_0400,
    32'h2000_8000, 32'h0400_1000, 32'h0008_0000, 32'h3c01_0000, 32'h3c02_0000,
    32'h0000_0000, 32'h0200_0000};

  apie_host_model u_host (.clk(clk), .cmdWrite(cmdWrite), .cmdResetPos(cmdResetPos),
    .errClrWrite(errClrWrite), .errClrData(errClrData), .positionResetN(positionResetN),
    .axisResetIn(axisResetIn));

  apie_top u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .clockSourceSelectHi(selHi),
    .clockSourceSelectLo(selLo), .isSlave(isSlave), .presetSel(presetSel),
    .presetValue(presetValue), .rowResetEn(rowResetEn), .axisResetIn(axisResetIn),
    .positionResetN(positionResetN), .cmdWrite(cmdWrite), .cmdResetPos(cmdResetPos),
    .posDelta(posDelta), .chanUse(chanUse), .acHigh(acHigh), .dcHigh(dcHigh),
    .belowSquelch(belowSquelch), .phaseTrackFailure(phaseTrackFailure),
    .overTemp(overTemp), .bpPllUnlock(bpPllUnlock), .refErrBits(refErrBits),
    .cmpHit(cmpHit), .errClrWrite(errClrWrite), .errClrData(errClrData),
    .irqMask(irqMask), .axisErrMask(axisErrMask), .axisPosition(axisPosition),
    .boardErrorStatus(boardErrorStatus), .irqOut(irqOut), .errLineOut(errLineOut),
    .chainDataInvalid(chainDataInvalid), .useBackplaneClk(useBackplaneClk),
    .bpClkOe(bpClkOe));

  // Board clock, 25 ns period.
  always #12.5 clk = ~clk;

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step

  // Case equality so an unknown output never counts as a match.
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    nTests = nTests + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // Raise one fault cause for a single cycle; case 9 forces a signed wrap of axis 4.
  task automatic fire(input int k);
    @(posedge clk);
    case (k)
      0: acHigh <= 4'h1;
      1: dcHigh <= 4'h2;
      2: belowSquelch <= 4'h4;
      3: phaseTrackFailure <= 4'h8;
      4: overTemp <= 4'h1;
      5: cmpHit <= 4'h2;
      6: bpPllUnlock <= 1'b1;
      7, 8: refErrBits <= 8'h20;
      default: u_host.sendCmd(4'h8);
    endcase
    @(posedge clk);
    {acHigh, dcHigh, belowSquelch, phaseTrackFailure, overTemp, cmpHit} <= 24'h00_0000;
    bpPllUnlock <= 1'b0;
    refErrBits  <= 8'h00;
  endtask : fire

  // The whole run is a few hundred cycles; the limit leaves a wide margin.
  initial
  begin
    step(3000);
    errors = errors + 1;
    summarize();
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {selHi, selLo, isSlave, bpPllUnlock} = 4'h0;
    {presetSel, rowResetEn, cmpHit, acHigh, dcHigh} = 20'h0_0000;
    {belowSquelch, phaseTrackFailure, overTemp, refErrBits} = 20'h0_0000;
    irqMask = 32'h0000_0001;
    errors = 0;
    nTests = 0;
    for (int i = 0; i < 4; i++)
    begin
      presetValue[i] = 32'h0000_0000;
      posDelta[i]    = 8'sh01;
      chanUse[i]     = 4'h1 << i;
      axisErrMask[i] = 32'h0000_0000;
    end
    axisErrMask[2] = 32'h0008_0000;
    step(6);
    check(axisPosition[0], 32'h0000_0000, "reset position");
    step(2);
    rst_n <= 1'b1;
    step(3);
    check(boardErrorStatus, 32'h0000_0000, "reset status");
    $display("test reset done");
    // Every select code, then code 1 on a slave board.
    for (int c = 0; c < 5; c++)
    begin
      @(posedge clk);
      {selHi, selLo} <= (c == 4) ? 2'h1 : c[1:0];
      isSlave <= (c == 4);
      step(3);
      check(useBackplaneClk, (c == 1), "clock use");
      check(bpClkOe, (c == 3), "clock drive");
    end
    {selHi, selLo} <= 2'h1;
    isSlave <= 1'b0;
    $display("test clock select done");
    // Software load: axis 1 zero, axis 2 preset, axis 3 untouched.
    presetSel <= 4'h2;
    presetValue[1] <= 32'h1234_5678;
    for (int i = 0; i < 4; i++)
      posDelta[i] <= 8'sh00;
    step(2);
    p2 = axisPosition[2];
    u_host.sendCmd(4'h3);
    step(3);
    check(axisPosition[0], 32'h0000_0000, "cmd zero");
    check(axisPosition[1], 32'h1234_5678, "cmd preset");
    check(axisPosition[2], p2, "cmd other axis");
    presetValue[1] <= 32'h0000_0abc;
    step(3);
    check(axisPosition[1], 32'h1234_5678, "single load");
    $display("test command load done");
    // Hardware reset line held low while counters run.
    for (int i = 0; i < 4; i++)
      posDelta[i] <= 8'sh05;
    u_host.setLines(1'b0, 4'h0);
    step(4);
    check(axisPosition[0], 32'h0000_0000, "hw zero");
    check(axisPosition[3], 32'h0000_0000, "hw zero other");
    check(axisPosition[1], 32'h0000_0abc, "hw preset");
    u_host.setLines(1'b1, 4'h0);
    step(3);
    check(axisPosition[3] == 32'h0000_0000, 32'h0, "hw released");
    $display("test hardware reset done");
    // Row reset: only the enabled axis with a high input is held at zero.
    rowResetEn <= 4'h4;
    u_host.setLines(1'b1, 4'h5);
    step(3);
    check(axisPosition[2], 32'h0000_0000, "row reset");
    check(axisPosition[0] == 32'h0000_0000, 32'h0, "row gated");
    u_host.setLines(1'b1, 4'h0);
    rowResetEn <= 4'h0;
    presetSel <= 4'h8;
    presetValue[3] <= 32'h7fff_fffe;
    posDelta[3] <= 8'sh04;
    $display("test row reset done");
    // Each fault but case 8 latches and survives a zero write, then clears through its data not valid bits, or directly if it sets none.
    for (int k = 0; k < 10; k++)
    begin
      @(posedge clk);
      isSlave <= (k == 7);
      step(2);
      fire(k);
      step(3);
      check(boardErrorStatus, expTab[k], "latch");
      check(irqOut, expTab[k][0], "irq mask");
      check(errLineOut, expTab[k][19], "line mask");
      if (k == 6)
        check(chainDataInvalid, 32'h1, "chain invalid");
      u_host.sendClr(32'h0000_0000);
      step(2);
      check(boardErrorStatus, expTab[k], "zero write");
      u_host.sendClr((expTab[k][29:26] != 4'h0) ? (expTab[k] & 32'h3c00_0000)
                                                 : expTab[k]);
      step(3);
      check(boardErrorStatus, 32'h0000_0000, "clear");
      $display("test fault case %0d done", k);
    end
    summarize();
  end
endmodule : apie_top_tb_top
